// ### design/hbp_consts.vh
// Constants for the half-bridge protection timing block
`ifndef HBP_CONSTS_VH
`define HBP_CONSTS_VH
`define HBP_CLK_NS 50
`define HBP_CYC(ns) (((ns) + `HBP_CLK_NS - 1) / `HBP_CLK_NS)
`define HBP_CCP0_NS 375
`define HBP_CCP1_NS 625
`define HBP_CCP2_NS 1000
`define HBP_CCP3_NS 1500
`define HBP_CCP4_NS 2000
`define HBP_CCP5_NS 3000
`define HBP_CCP6_NS 4000
`define HBP_CCP7_NS 16000
`define HBP_BLK0_NS 625
`define HBP_BLK1_NS 1000
`define HBP_BLK2_NS 1250
`define HBP_BLK3_NS 1500
`define HBP_BLK4_NS 2000
`define HBP_BLK5_NS 3000
`define HBP_BLK6_NS 4000
`define HBP_BLK7_NS 16000
`define HBP_FLT0_NS 500
`define HBP_FLT1_NS 1000
`define HBP_FLT2_NS 2000
`define HBP_FLT3_NS 3000
`define HBP_A_GEN 4'h0
`define HBP_A_MODE 4'h1
`define HBP_A_PWMSEL 4'h2
`define HBP_A_MAP 4'h3
`define HBP_A_ACT 4'h4
`define HBP_A_FW 4'h5
`define HBP_A_THR 4'h6
`define HBP_A_REF 4'h7
`define HBP_A_STAT 4'h8
`define HBP_A_GSTAT 4'h9
`define HBP_GEN_PASS 0
`define HBP_GEN_GENCHK 1
`define HBP_GEN_TF 2
`define HBP_GEN_PWMEN 4
`define HBP_RST_GEN 8'h01
`define HBP_RST_MODE 16'h0000
`define HBP_RST_PWMSEL 16'h0000
`define HBP_RST_MAP 16'h0000
`define HBP_RST_TIMING 24'h924924
`define HBP_RST_THR 24'h249249
`define HBP_RST_REF 8'h00
`endif

// ### design/hbp_protect.v
// Dead time, blank time, drain-source filter and fault latch for eight half-bridges
`timescale 1ns/1ps
`include "hbp_consts.vh"
module hbp_protect #(
  parameter NB = 8
) (
  input  wire          clk,
  input  wire          resetn,
  input  wire [3:0]    addr,
  input  wire [23:0]   wdata,
  input  wire          wr,
  input  wire          rd,
  output reg  [23:0]   rdata,
  input  wire          en_pin,
  input  wire [2:0]    pwm_pin,
  input  wire [NB-1:0] hs_cmp_dh,
  input  wire [NB-1:0] hs_cmp_cs,
  input  wire [NB-1:0] ls_cmp_sl,
  output reg  [NB-1:0] gate_hs,
  output reg  [NB-1:0] gate_ls,
  output reg  [NB-1:0] static_discharge,
  output reg  [23:0]   ds_threshold,
  output reg  [NB-1:0] drain_reference_select,
  output reg           global_ds_error_bit
);
  // One-hot sequencer states, one set per bridge
  localparam ST_OFF  = 4'b0001;
  localparam ST_HS   = 4'b0010;
  localparam ST_LS   = 4'b0100;
  localparam ST_DEAD = 4'b1000;

  // Terminal counts round up, so no duration comes out shorter than its typical value
  function [8:0] ccp_cyc;
    input [2:0] c;
    reg [31:0] t;
    begin
      case (c)
        3'h0: t = `HBP_CYC(`HBP_CCP0_NS);
        3'h1: t = `HBP_CYC(`HBP_CCP1_NS);
        3'h2: t = `HBP_CYC(`HBP_CCP2_NS);
        3'h3: t = `HBP_CYC(`HBP_CCP3_NS);
        3'h4: t = `HBP_CYC(`HBP_CCP4_NS);
        3'h5: t = `HBP_CYC(`HBP_CCP5_NS);
        3'h6: t = `HBP_CYC(`HBP_CCP6_NS);
        default: t = `HBP_CYC(`HBP_CCP7_NS);
      endcase
      ccp_cyc = t[8:0];
    end
  endfunction

  function [8:0] blk_cyc;
    input [2:0] c;
    reg [31:0] t;
    begin
      case (c)
        3'h0: t = `HBP_CYC(`HBP_BLK0_NS);
        3'h1: t = `HBP_CYC(`HBP_BLK1_NS);
        3'h2: t = `HBP_CYC(`HBP_BLK2_NS);
        3'h3: t = `HBP_CYC(`HBP_BLK3_NS);
        3'h4: t = `HBP_CYC(`HBP_BLK4_NS);
        3'h5: t = `HBP_CYC(`HBP_BLK5_NS);
        3'h6: t = `HBP_CYC(`HBP_BLK6_NS);
        default: t = `HBP_CYC(`HBP_BLK7_NS);
      endcase
      blk_cyc = t[8:0];
    end
  endfunction

  function [7:0] flt_cyc;
    input [1:0] c;
    reg [31:0] t;
    begin
      case (c)
        2'h0: t = `HBP_CYC(`HBP_FLT0_NS);
        2'h1: t = `HBP_CYC(`HBP_FLT1_NS);
        2'h2: t = `HBP_CYC(`HBP_FLT2_NS);
        default: t = `HBP_CYC(`HBP_FLT3_NS);
      endcase
      flt_cyc = t[7:0];
    end
  endfunction

  // Pair fields are {blank[5:3], dead[2:0]}
  function [5:0] pick_pair;
    input [23:0] v;
    input [1:0]  p;
    begin
      case (p)
        2'h0: pick_pair = v[5:0];
        2'h1: pick_pair = v[11:6];
        2'h2: pick_pair = v[17:12];
        default: pick_pair = v[23:18];
      endcase
    end
  endfunction

  reg  [7:0]    gen_q;
  reg  [15:0]   mode_q;
  reg  [15:0]   pwmsel_q;
  reg  [15:0]   map_q;
  reg  [23:0]   act_q;
  reg  [23:0]   fw_q;
  reg  [15:0]   stat_q;
  reg           en_m_q;
  reg           en_s_q;
  reg  [2:0]    pwm_m_q;
  reg  [2:0]    pwm_s_q;
  reg  [NB-1:0] dh_m_q;
  reg  [NB-1:0] dh_s_q;
  reg  [NB-1:0] cs_m_q;
  reg  [NB-1:0] cs_s_q;
  reg  [NB-1:0] sl_m_q;
  reg  [NB-1:0] sl_s_q;
  wire [15:0]   fault;
  wire          drv_ok;
  wire [2:0]    pwm_lvl;
  wire [7:0]    flt_lim;
  wire          wr_stat;
  reg  [15:0]   stat_d;

  // Two-flop synchronisers for all pins
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_m_q  <= 1'b0;
      en_s_q  <= 1'b0;
      pwm_m_q <= 3'h0;
      pwm_s_q <= 3'h0;
      dh_m_q  <= {NB{1'b0}};
      dh_s_q  <= {NB{1'b0}};
      cs_m_q  <= {NB{1'b0}};
      cs_s_q  <= {NB{1'b0}};
      sl_m_q  <= {NB{1'b0}};
      sl_s_q  <= {NB{1'b0}};
    end else begin
      en_m_q  <= en_pin;
      en_s_q  <= en_m_q;
      pwm_m_q <= pwm_pin;
      pwm_s_q <= pwm_m_q;
      dh_m_q  <= hs_cmp_dh;
      dh_s_q  <= dh_m_q;
      cs_m_q  <= hs_cmp_cs;
      cs_s_q  <= cs_m_q;
      sl_m_q  <= ls_cmp_sl;
      sl_s_q  <= sl_m_q;
    end
  end

  // Pin paths lag two cycles; dead, blank and filter counts do not include this
  assign drv_ok  = en_s_q & ~gen_q[`HBP_GEN_PASS];
  // A channel whose enable bit is clear reads as low level
  assign pwm_lvl = pwm_s_q & gen_q[`HBP_GEN_PWMEN +: 3];
  assign flt_lim = flt_cyc(gen_q[`HBP_GEN_TF +: 2]);
  assign wr_stat = wr & (addr == `HBP_A_STAT);

  // Set wins over the host's clear
  always @* begin
    stat_d = stat_q;
    if (wr_stat)
      stat_d = stat_d & ~wdata[15:0];
    stat_d = stat_d | fault;
  end

  // Writes land at the strobe edge; read data stand for one cycle only
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gen_q                  <= `HBP_RST_GEN;
      mode_q                 <= `HBP_RST_MODE;
      pwmsel_q               <= `HBP_RST_PWMSEL;
      map_q                  <= `HBP_RST_MAP;
      act_q                  <= `HBP_RST_TIMING;
      fw_q                   <= `HBP_RST_TIMING;
      ds_threshold           <= `HBP_RST_THR;
      drain_reference_select <= `HBP_RST_REF;
      stat_q                 <= 16'h0000;
      global_ds_error_bit    <= 1'b0;
      rdata                  <= 24'h000000;
    end else begin
      stat_q              <= stat_d;
      global_ds_error_bit <= |stat_d;
      if (wr) begin
        case (addr)
          `HBP_A_GEN:    gen_q <= wdata[7:0];
          `HBP_A_MODE:   mode_q <= wdata[15:0];
          `HBP_A_PWMSEL: pwmsel_q <= wdata[15:0];
          `HBP_A_MAP:    map_q <= wdata[15:0];
          `HBP_A_ACT:    act_q <= wdata;
          `HBP_A_FW:     fw_q <= wdata;
          `HBP_A_THR:    ds_threshold <= wdata;
          `HBP_A_REF:    drain_reference_select <= wdata[NB-1:0];
          default: ;
        endcase
      end
      rdata <= 24'h000000;
      if (rd) begin
        case (addr)
          `HBP_A_GEN:    rdata <= {16'h0000, gen_q};
          `HBP_A_MODE:   rdata <= {8'h00, mode_q};
          `HBP_A_PWMSEL: rdata <= {8'h00, pwmsel_q};
          `HBP_A_MAP:    rdata <= {8'h00, map_q};
          `HBP_A_ACT:    rdata <= act_q;
          `HBP_A_FW:     rdata <= fw_q;
          `HBP_A_THR:    rdata <= ds_threshold;
          `HBP_A_REF:    rdata <= {16'h0000, drain_reference_select};
          `HBP_A_STAT:   rdata <= {8'h00, stat_q};
          `HBP_A_GSTAT:  rdata <= {23'h0, global_ds_error_bit};
          default:       rdata <= 24'h000000;
        endcase
      end
    end
  end

  // Each bridge runs its own sequencer; the four timing pairs and the filter time are shared
  genvar b;
  generate
    for (b = 0; b < NB; b = b + 1) begin : g_br
      wire [1:0] mode = mode_q[2*b+1:2*b];
      wire [1:0] sel  = pwmsel_q[2*b+1:2*b];
      wire       act_hs = (mode == 2'b10);
      wire       act_ls = (mode == 2'b01);
      wire       is_pwm = (sel != 2'b00);
      wire       lvl = is_pwm ? pwm_lvl[sel - 2'b01] : 1'b1;
      wire       want_hs = (act_hs & lvl) | (act_ls & is_pwm & ~lvl);
      wire       want_ls = (act_ls & lvl) | (act_hs & is_pwm & ~lvl);
      wire [5:0] pa = pick_pair(act_q, map_q[2*b+1:2*b]);
      wire [5:0] pf = pick_pair(fw_q, map_q[2*b+1:2*b]);
      wire       latched = stat_q[2*b] | stat_q[2*b+1];
      wire       run = drv_ok & ~latched;
      // Comparator of the MOSFET that is on; reference choice per bridge
      wire       hs_mon = drain_reference_select[b] ? cs_s_q[b] : dh_s_q[b];
      wire       mon = (gate_hs[b] & hs_mon) | (gate_ls[b] & sl_s_q[b]);
      reg  [3:0] st_q;
      reg  [8:0] dead_q;
      reg  [8:0] blk_q;
      reg  [7:0] flt_q;
      reg        early_q;
      reg        hit_q;
      reg        hit_hs_q;
      // On a bridge not driven from a PWM channel, a short already present at blank end doubles the filter limit
      wire [7:0] lim = early_q ? {flt_lim[6:0], 1'b0} : flt_lim;
      // Static drive follows the status bits exactly, so it drops with the host's clear
      wire       stat_any = stat_d[2*b] | stat_d[2*b+1];

      assign fault[2*b]   = hit_q & ~hit_hs_q;
      assign fault[2*b+1] = hit_q & hit_hs_q;

      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          st_q                <= ST_OFF;
          dead_q              <= 9'h000;
          blk_q               <= 9'h000;
          flt_q               <= 8'h00;
          early_q             <= 1'b0;
          hit_q               <= 1'b0;
          hit_hs_q            <= 1'b0;
          gate_hs[b]          <= 1'b0;
          gate_ls[b]          <= 1'b0;
          static_discharge[b] <= 1'b0;
        end else begin
          hit_q               <= 1'b0;
          static_discharge[b] <= stat_any;
          if (!run || hit_q) begin
            // Fault or disable: both gates off at once
            st_q       <= ST_OFF;
            gate_hs[b] <= 1'b0;
            gate_ls[b] <= 1'b0;
            blk_q      <= 9'h000;
            flt_q      <= 8'h00;
            early_q    <= 1'b0;
          end else begin
            case (st_q)
              ST_OFF: begin
                // From high impedance the blank starts with the turn-on itself
                if (want_hs) begin
                  st_q       <= ST_HS;
                  gate_hs[b] <= 1'b1;
                  blk_q      <= blk_cyc(act_hs ? pa[5:3] : pf[5:3]);
                end else if (want_ls) begin
                  st_q       <= ST_LS;
                  gate_ls[b] <= 1'b1;
                  blk_q      <= blk_cyc(act_ls ? pa[5:3] : pf[5:3]);
                end
                flt_q   <= 8'h00;
                early_q <= 1'b0;
              end
              ST_HS: begin
                if (!want_hs) begin
                  // Every turn-off on a dropped request passes dead time, so a quick re-request cannot overlap
                  st_q       <= ST_DEAD;
                  gate_hs[b] <= 1'b0;
                  dead_q     <= ccp_cyc(act_hs ? pa[2:0] : pf[2:0]);
                end
              end
              ST_LS: begin
                if (!want_ls) begin
                  st_q       <= ST_DEAD;
                  gate_ls[b] <= 1'b0;
                  dead_q     <= ccp_cyc(act_ls ? pa[2:0] : pf[2:0]);
                end
              end
              ST_DEAD: begin
                flt_q   <= 8'h00;
                early_q <= 1'b0;
                if (dead_q > 9'h001) begin
                  dead_q <= dead_q - 9'h001;
                end else if (want_hs) begin
                  // Blank follows expiry of the preceding dead time
                  st_q       <= ST_HS;
                  gate_hs[b] <= 1'b1;
                  blk_q      <= blk_cyc(act_hs ? pa[5:3] : pf[5:3]);
                end else if (want_ls) begin
                  st_q       <= ST_LS;
                  gate_ls[b] <= 1'b1;
                  blk_q      <= blk_cyc(act_ls ? pa[5:3] : pf[5:3]);
                end else begin
                  st_q <= ST_OFF;
                end
              end
              default: begin
                st_q       <= ST_OFF;
                gate_hs[b] <= 1'b0;
                gate_ls[b] <= 1'b0;
              end
            endcase
            // Blank first, then the filter; any drop of the comparator restarts the filter
            if ((st_q == ST_HS) || (st_q == ST_LS)) begin
              if (blk_q != 9'h000) begin
                blk_q <= blk_q - 9'h001;
                if (blk_q == 9'h001)
                  early_q <= mon & ~is_pwm;
              end else if (mon) begin
                // Only a continuous assertion counts
                if (flt_q >= lim) begin
                  hit_q    <= 1'b1;
                  hit_hs_q <= gate_hs[b];
                end else begin
                  flt_q <= flt_q + 8'h01;
                end
              end else begin
                flt_q   <= 8'h00;
                early_q <= 1'b0;
              end
            end
          end
        end
      end
    end
  endgenerate
endmodule // hbp_protect

// ### tb/hbp_protect_asserts.sv
// Assertion checker for the half-bridge protection block
`timescale 1ns/1ps
module hbp_protect_asserts #(
  parameter NB = 8
) (
  input wire          clk,
  input wire          resetn,
  input wire [3:0]    addr,
  input wire [23:0]   wdata,
  input wire          wr,
  input wire          rd,
  input wire [23:0]   rdata,
  input wire          en_pin,
  input wire [2:0]    pwm_pin,
  input wire [NB-1:0] hs_cmp_dh,
  input wire [NB-1:0] hs_cmp_cs,
  input wire [NB-1:0] ls_cmp_sl,
  input wire [NB-1:0] gate_hs,
  input wire [NB-1:0] gate_ls,
  input wire [NB-1:0] static_discharge,
  input wire [23:0]   ds_threshold,
  input wire [NB-1:0] drain_reference_select,
  input wire          global_ds_error_bit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  no_overlap_a: assert property ((gate_hs & gate_ls) == {NB{1'b0}})
    else $error("both gates of a bridge on");
  hs_dead_a: assert property ($fell(gate_hs[0]) |-> (gate_ls[0] == 1'b0) [*8])
    else $error("low side on inside dead time");
  ls_dead_a: assert property ($fell(gate_ls[0]) |-> (gate_hs[0] == 1'b0) [*8])
    else $error("high side on inside dead time");
  blank_hold_a: assert property ($rose(gate_ls[0]) |=> (static_discharge[0] == 1'b0) [*8])
    else $error("fault inside blank time");
  filter_len_a: assert property ($rose(static_discharge[0]) |-> $past(ls_cmp_sl[0] | hs_cmp_dh[0], 6))
    else $error("fault without filtered comparator");
  latch_off_a: assert property (static_discharge[0] |-> !gate_hs[0] && !gate_ls[0])
    else $error("latched bridge still driven");
  glob_err_a: assert property (|static_discharge |-> global_ds_error_bit)
    else $error("global error bit missing");
  en_off_a: assert property ($fell(en_pin) |-> ##[1:5] (gate_hs == {NB{1'b0}} && gate_ls == {NB{1'b0}}))
    else $error("gates on after enable low");
  thr_wr_a: assert property (wr && addr == 4'h6 |=> ds_threshold == $past(wdata))
    else $error("threshold output not updated");
  ref_wr_a: assert property (wr && addr == 4'h7 |=> drain_reference_select == $past(wdata[NB-1:0]))
    else $error("reference select not updated");
  cover property ($rose(static_discharge[0]));
  cover property ($fell(gate_hs[0]) ##[1:60] $rose(gate_ls[0]));
  cover property ($fell(en_pin));
endmodule // hbp_protect_asserts

bind hbp_protect hbp_protect_asserts #(.NB(NB)) u_chk (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .en_pin(en_pin), .pwm_pin(pwm_pin), .hs_cmp_dh(hs_cmp_dh), .hs_cmp_cs(hs_cmp_cs),
  .ls_cmp_sl(ls_cmp_sl), .gate_hs(gate_hs), .gate_ls(gate_ls), .static_discharge(static_discharge),
  .ds_threshold(ds_threshold), .drain_reference_select(drain_reference_select),
  .global_ds_error_bit(global_ds_error_bit)
);

// ### tb/hbp_fet_model.sv
// External MOSFET and drain-source comparator model for the half-bridges
`timescale 1ns/1ps
module hbp_fet_model #(
  parameter NB = 8
) (
  input  wire          clk,
  input  wire [NB-1:0] gate_hs,
  input  wire [NB-1:0] gate_ls,
  input  wire [NB-1:0] short_hs,
  input  wire [NB-1:0] short_ls,
  output wire [NB-1:0] hs_cmp_dh,
  output wire [NB-1:0] hs_cmp_cs,
  output wire [NB-1:0] ls_cmp_sl
);
  reg junk_q;
  initial junk_q = 1'b0;
  // An off MOSFET gives no valid reading, so its comparator chatters
  always @(posedge clk) junk_q <= ~junk_q;
  assign hs_cmp_dh = (gate_hs & short_hs) | (~gate_hs & {NB{junk_q}});
  assign hs_cmp_cs = hs_cmp_dh;
  assign ls_cmp_sl = (gate_ls & short_ls) | (~gate_ls & {NB{junk_q}});
endmodule // hbp_fet_model

// ### tb/hbp_protect_tb.sv
// Self-checking testbench for the half-bridge protection block
`timescale 1ns/1ps
module hbp_protect_tb;
  reg          clk;
  reg          resetn;
  reg  [3:0]   addr;
  reg  [23:0]  wdata;
  reg          wr;
  reg          rd;
  reg          en_pin;
  reg  [7:0]   short_ls;
  reg  [7:0]   short_hs;
  reg  [2:0]   pwm_pin;
  wire [23:0]  rdata;
  wire [7:0]   hs_cmp_dh;
  wire [7:0]   hs_cmp_cs;
  wire [7:0]   ls_cmp_sl;
  wire [7:0]   gate_hs;
  wire [7:0]   gate_ls;
  wire [7:0]   static_discharge;
  wire [23:0]  ds_threshold;
  wire [7:0]   drain_reference_select;
  wire         global_ds_error_bit;
  integer      num_errors;
  integer      n_compared;
  integer      mdl [0:7];
  integer      n;
  integer      i;
  integer      d;
  reg  [31:0]  rnd;

  hbp_protect #(.NB(8)) uut (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .en_pin(en_pin), .pwm_pin(pwm_pin), .hs_cmp_dh(hs_cmp_dh), .hs_cmp_cs(hs_cmp_cs), .ls_cmp_sl(ls_cmp_sl),
    .gate_hs(gate_hs), .gate_ls(gate_ls), .static_discharge(static_discharge), .ds_threshold(ds_threshold),
    .drain_reference_select(drain_reference_select), .global_ds_error_bit(global_ds_error_bit)
  );
  hbp_fet_model #(.NB(8)) u_fet (
    .clk(clk), .gate_hs(gate_hs), .gate_ls(gate_ls), .short_hs(short_hs), .short_ls(short_ls),
    .hs_cmp_dh(hs_cmp_dh), .hs_cmp_cs(hs_cmp_cs), .ls_cmp_sl(ls_cmp_sl)
  );

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [23:0] msk(input [3:0] a);
    msk = (a == 4'h0 || a == 4'h7) ? 24'hff : (a < 4'h4) ? 24'hffff : 24'hffffff;
  endfunction
  task chk(input ok, input [8*12:1] msg);
    begin
      n_compared = n_compared + 1;
      if (!ok) begin
        num_errors = num_errors + 1;
        $display("BAD %0t %0s", $time, msg);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [23:0] v);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      if (a < 4'h8) mdl[a] = v & msk(a);
    end
  endtask
  task rd_reg(input [3:0] a, input [23:0] e);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata === e, "read");
    end
  endtask
  // Counts cycles until bridge 0 gate reaches v; ls picks the low side
  task wait_g(input ls, input v);
    begin
      n = 0;
      while ((ls ? gate_ls[0] : gate_hs[0]) !== v && n < 4000) begin
        @(negedge clk);
        n = n + 1;
      end
    end
  endtask
  task conclude;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    num_errors = num_errors + 1;
    conclude;
  end
  initial begin
    resetn = 1'b0; addr = 4'h0; wdata = 24'h0; wr = 1'b0; rd = 1'b0;
    en_pin = 1'b1; short_ls = 8'h0; num_errors = 0; n_compared = 0; rnd = 32'h2a37;
    short_hs = 8'h0; pwm_pin = 3'h0;
    for (i = 0; i < 8; i = i + 1) mdl[i] = (i == 0) ? 1 : (i == 4 || i == 5) ? 24'h924924 : (i == 6) ? 24'h249249 : 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1) rd_reg(i[3:0], mdl[i][23:0]);
    rd_reg(4'ha, 24'h0);
    chk(ds_threshold === 24'h249249, "thr reset");
    for (i = 0; i < 4; i = i + 1) begin
      rnd = lfsr(rnd);
      wr_reg(4'h6, rnd[23:0]);
      wr_reg(4'h7, {16'h0, rnd[31:24]});
      rd_reg(4'h6, mdl[6][23:0]);
      rd_reg(4'h7, mdl[7][23:0]);
      chk(ds_threshold === rnd[23:0], "thr out");
      chk(drain_reference_select === rnd[31:24], "ref out");
    end
    wr_reg(4'h6, 24'h249249);
    $display("test registers done");
    wr_reg(4'h0, 24'h0);
    for (i = 0; i < 2; i = i + 1) begin
      d = i ? 8 : 40;
      wr_reg(4'h3, i ? 24'h1 : 24'h0);
      wr_reg(4'h4, i ? 24'h924024 : 24'h924924);
      wr_reg(4'h5, i ? 24'h924024 : 24'h924924);
      wr_reg(4'h1, 24'h2);
      wait_g(1'b0, 1'b1);
      repeat (60) @(negedge clk);
      wr_reg(4'h1, 24'h1);
      wait_g(1'b0, 1'b0);
      wait_g(1'b1, 1'b1);
      chk(n >= d && n <= d + 2, "dead time");
      wr_reg(4'h1, 24'h0);
      repeat (60) @(negedge clk);
    end
    $display("test dead time done");
    for (i = 0; i < 4; i = i + 1) begin
      d = (i == 0) ? 10 : (i == 3) ? 60 : 20 * i;
      wr_reg(4'h0, {20'h0, i[1:0], 2'b00});
      wr_reg(4'h1, 24'h1);
      wait_g(1'b1, 1'b1);
      repeat (30) @(negedge clk);
      @(posedge clk);
      short_ls <= 8'h01;
      wait_g(1'b1, 1'b0);
      chk(n > d && n <= d + 6, "filter");
      @(negedge clk);
      chk(static_discharge[0] === 1'b1 && global_ds_error_bit === 1'b1, "latch");
      rd_reg(4'h8, 24'h1);
      rd_reg(4'h9, 24'h1);
      @(posedge clk);
      short_ls <= 8'h0;
      repeat (20) @(negedge clk);
      chk(gate_ls[0] === 1'b0, "stays off");
      wr_reg(4'h8, 24'h1);
      wait_g(1'b1, 1'b1);
      chk(n < 10, "re-enable");
      wr_reg(4'h1, 24'h0);
      repeat (30) @(negedge clk);
    end
    $display("test filter done");
    wr_reg(4'h0, 24'h0);
    @(posedge clk);
    short_ls <= 8'h01;
    wr_reg(4'h1, 24'h1);
    wait_g(1'b1, 1'b1);
    wait_g(1'b1, 1'b0);
    chk(n >= 31 && n <= 37, "static");
    @(posedge clk);
    short_ls <= 8'h0;
    wr_reg(4'h8, 24'h1);
    wr_reg(4'h1, 24'h2);
    $display("test static short done");
    wait_g(1'b0, 1'b1);
    @(posedge clk);
    en_pin <= 1'b0;
    repeat (6) @(negedge clk);
    chk(gate_hs === 8'h0 && gate_ls === 8'h0, "enable");
    @(posedge clk);
    en_pin <= 1'b1;
    wait_g(1'b0, 1'b1);
    wr_reg(4'h0, 24'h1);
    repeat (6) @(negedge clk);
    chk(gate_hs === 8'h0 && gate_ls === 8'h0, "passive");
    $display("test enable done");
    // Pair 1: active dead 8 cycles, freewheel dead 20 cycles
    wr_reg(4'h5, 24'h9240a4);
    wr_reg(4'h2, 24'h1);
    @(posedge clk);
    pwm_pin <= 3'h1;
    wr_reg(4'h0, 24'h10);
    wait_g(1'b0, 1'b1);
    repeat (30) @(negedge clk);
    @(posedge clk);
    pwm_pin <= 3'h0;
    wait_g(1'b0, 1'b0);
    wait_g(1'b1, 1'b1);
    chk(n >= 8 && n <= 10, "pwm act dead");
    repeat (30) @(negedge clk);
    @(posedge clk);
    pwm_pin <= 3'h1;
    wait_g(1'b1, 1'b0);
    wait_g(1'b0, 1'b1);
    chk(n >= 20 && n <= 22, "pwm fw dead");
    $display("test pwm done");
    wr_reg(4'h2, 24'h0);
    repeat (40) @(negedge clk);
    @(posedge clk);
    short_hs <= 8'h01;
    wait_g(1'b0, 1'b0);
    chk(n > 10 && n <= 16, "hs filter");
    rd_reg(4'h8, 24'h2);
    @(posedge clk);
    short_hs <= 8'h0;
    wr_reg(4'h8, 24'h2);
    wr_reg(4'h0, 24'h1);
    $display("test high side short done");
    conclude;
  end
endmodule // hbp_protect_tb
